/* src/hbc_bridge_ctrl.sv */
// Brushed DC H-bridge control: input decode, regulation, protection.
// Assumes synchronous inputs, analog monitors presented as logic levels.
//
// Overview of operation
// - Decode inputs to coast, reverse, forward, brake.
// - Coast disables bridge, sleep after interval.
// - Follow static or toggled drive patterns.
// - Dead time on every half-bridge side change.
// - Debounce each control input.
// - Sense enable drops at once with low-side.
// - Sense stays on through drive/brake toggling.
// - Trip forces brake for fixed off-time.
// - After off-time, resume or brake again.
// - Input change aborts off-time immediately.
// - Blank trip after enable, then debounce.
// - Outputs off until supply above threshold.
// - Supply drop disables and resets logic.
// - Any FET overcurrent for response time: all off.
// - Retry after interval, repeat while faulted.
// - Overcurrent checked per FET, independent.
// - Thermal shutdown with hysteresis release.
// - Off-time is 25 microseconds.
// - Blanking is 1.4 microseconds.
// - Trip debounce is 0.7 microseconds.
`timescale 1ns/1ps
`default_nettype none
module hbc_bridge_ctrl
	import hbc_pkg::*;
#(
	parameter int RETRY_CYC = RETRY_CYC_DEF,           // Overcurrent retry interval
	parameter int SLEEP_CYC = SLEEP_CYC_DEF            // Coast time before sleep
) (
	input  wire  logic      sys_clk_in,         // 100 MHz clock
	input  wire  logic      nrst_in,            // Async reset, active low
	input  wire  logic      ctrl_in_a,          // Host control input A
	input  wire  logic      ctrl_in_b,          // Host control input B
	input  wire  logic      trip_current_in,    // Regulation comparator
	input  wire  hbc_mon_t  mon_in,             // Supply, thermal, overcurrent
	output var   hbc_gate_t bridge_out_a,       // Gates of output A
	output var   hbc_gate_t bridge_out_b,       // Gates of output B
	output var   logic      sense_en_out,       // Current sense enable
	output var   logic      sense_ready_out,    // Sense output valid
	output var   hbc_stat_t status_out          // Status flags
);

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		hbc_state_t       state;            // Main control state
		logic [1:0]       in_q;             // Debounced inputs {a,b}
		logic [1:0]       in_raw;           // Last raw inputs
		logic [INDEB_W-1:0] in_cnt;         // Input stability counter
		logic [CNT_W-1:0] tmr;              // Off-time / retry / sleep timer
		logic [CNT_W-1:0] blank;            // Trip blanking counter
		logic [CNT_W-1:0] tdeb;             // Trip debounce counter
		logic [3:0][CNT_W-1:0] oc_cnt;      // Per-FET overcurrent filters
		logic             therm;            // Thermal shutdown latch
		logic             uv;               // Undervoltage lockout latch
		logic             sense_on;         // Sense enable
		logic [CNT_W-1:0] sdly;             // Sense ready delay
	} hbc_ctl_state_t;

	hbc_ctl_state_t st_r;
	hbc_ctl_state_t st_nxt;

	// ------------------------------------------------------------
	// Derived combinational terms
	// ------------------------------------------------------------
	logic       oc_trip;                    // Some FET exceeded response time
	logic       fault;                      // Any protection active
	logic       in_changed;                 // Debounced input changed this cycle
	logic [1:0] in_new;                     // Debounced input next value
	hbc_drv_t   req_a;                      // Drive request, side A
	hbc_drv_t   req_b;                      // Drive request, side B
	logic       kill;                       // Immediate gate kill
	logic [3:0] oc_hit;                     // Per-FET timed-out flags

	// Per-FET overcurrent filters, one each
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_oc
			assign oc_hit[g] = (st_r.oc_cnt[g] >= CNT_W'(OCR_CYC));
		end
	endgenerate

	assign oc_trip = |oc_hit;
	assign fault   = st_r.uv || st_r.therm || st_r.state == HBC_ST_OCOFF;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		in_new = st_r.in_q;

		// Input filter: a level must hold INDEB_CYC cycles to count
		st_nxt.in_raw = {ctrl_in_a, ctrl_in_b};
		if ({ctrl_in_a, ctrl_in_b} != st_r.in_raw) begin
			st_nxt.in_cnt = '0;
		end else if (st_r.in_cnt < INDEB_W'(INDEB_CYC)) begin
			st_nxt.in_cnt = st_r.in_cnt + 1'b1;
		end else begin
			in_new = st_r.in_raw;
		end
		st_nxt.in_q = in_new;
		in_changed  = (in_new != st_r.in_q);

		// Supply monitor; hysteresis sits in the analog comparator
		st_nxt.uv = !mon_in.uv_ok;

		// Thermal latch; monitor deasserts only below release margin
		st_nxt.therm = mon_in.thermal_limit;

		// Overcurrent filters count while their detector stays high
		for (int i = 0; i < 4; i++) begin
			if (!mon_in.oc_det[i] || st_r.state == HBC_ST_OCOFF) begin
				st_nxt.oc_cnt[i] = '0;
			end else if (!oc_hit[i]) begin
				st_nxt.oc_cnt[i] = st_r.oc_cnt[i] + 1'b1;
			end
		end

		// Timer decrement
		if (st_r.tmr != '0) begin
			st_nxt.tmr = st_r.tmr - 1'b1;
		end
		if (st_r.blank != '0) begin
			st_nxt.blank = st_r.blank - 1'b1;
		end

		// Trip debounce, only after blanking
		if (trip_current_in && st_r.blank == '0) begin
			if (st_r.tdeb < CNT_W'(TDEB_CYC)) begin
				st_nxt.tdeb = st_r.tdeb + 1'b1;
			end
		end else begin
			st_nxt.tdeb = '0;
		end

		case (st_r.state)
			HBC_ST_SLEEP: begin
				// Wake on any non-coast command
				if (in_new != 2'h0 && !st_r.uv && !st_r.therm) begin
					st_nxt.state = HBC_ST_RUN;
					st_nxt.blank = CNT_W'(BLANK_CYC);
				end
			end
			HBC_ST_RUN: begin
				if (in_new == 2'h0) begin
					if (in_changed) begin
						st_nxt.tmr = CNT_W'(SLEEP_CYC);
					end else if (st_r.tmr == '0) begin
						st_nxt.state = HBC_ST_SLEEP;
					end
				end else if (st_r.tdeb >= CNT_W'(TDEB_CYC) && st_r.blank == '0 && !in_changed) begin
					st_nxt.state = HBC_ST_REGOFF;
					st_nxt.tmr   = CNT_W'(OFF_CYC);
					st_nxt.tdeb  = '0;
				end else if (in_changed && st_r.in_q == 2'h0) begin
					st_nxt.blank = CNT_W'(BLANK_CYC);
				end
				// Blanking starts once the gates are really on, not inside the dead gap
				if (in_new != 2'h0 && st_nxt.state == HBC_ST_RUN && {bridge_out_a, bridge_out_b} == 4'h0) begin
					st_nxt.blank = CNT_W'(BLANK_CYC);
				end
			end
			HBC_ST_REGOFF: begin
				if (in_changed) begin
					st_nxt.state = HBC_ST_RUN;
					st_nxt.blank = CNT_W'(BLANK_CYC);
					st_nxt.tmr   = (in_new == 2'h0) ? CNT_W'(SLEEP_CYC) : '0;
				end else if (st_r.tmr == '0) begin
					if (trip_current_in) begin
						st_nxt.tmr = CNT_W'(OFF_CYC);
					end else begin
						st_nxt.state = HBC_ST_RUN;
						st_nxt.blank = CNT_W'(BLANK_CYC);
					end
				end
			end
			HBC_ST_OCOFF: begin
				// Retry with whatever the inputs now ask
				if (st_r.tmr == '0) begin
					st_nxt.state = HBC_ST_RUN;
					st_nxt.blank = CNT_W'(BLANK_CYC);
					st_nxt.tmr   = (in_new == 2'h0) ? CNT_W'(SLEEP_CYC) : '0;
				end
			end
			HBC_ST_LOCK: begin
				// Held by supply or thermal fault
				if (!st_r.uv && !st_r.therm) begin
					st_nxt.state = HBC_ST_SLEEP;
				end
			end
			default: begin
				st_nxt.state = HBC_ST_SLEEP;
			end
		endcase

		// Overcurrent beats regulation and decode
		if (oc_trip && st_r.state != HBC_ST_OCOFF && st_r.state != HBC_ST_LOCK) begin
			st_nxt.state = HBC_ST_OCOFF;
			st_nxt.tmr   = CNT_W'(RETRY_CYC);
		end
		// Supply and thermal faults beat everything else
		if (st_r.uv || st_r.therm) begin
			st_nxt.state = HBC_ST_LOCK;
			st_nxt.tmr   = '0;
			st_nxt.tdeb  = '0;
			st_nxt.oc_cnt = '0;
		end

		// Sense path: on while a low-side is commanded by the inputs
		// Drive/brake toggling keeps a low-side on, so the circuit stays on
		st_nxt.sense_on = (in_new != 2'h0) && !fault &&
			st_nxt.state != HBC_ST_SLEEP && st_nxt.state != HBC_ST_LOCK;
		if (!st_nxt.sense_on) begin
			st_nxt.sdly = CNT_W'(SENSE_CYC);
		end else if (st_r.sdly != '0) begin
			st_nxt.sdly = st_r.sdly - 1'b1;
		end
	end

	// Register all state; supply loss resets via uv latch path
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r       <= '0;
			st_r.state <= HBC_ST_LOCK;
			st_r.uv    <= 1'b1;
			st_r.sdly  <= CNT_W'(SENSE_CYC);
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Output decode
	// ------------------------------------------------------------
	always_comb begin
		kill  = 1'b0;
		req_a = HBC_DRV_OFF;
		req_b = HBC_DRV_OFF;
		case (st_r.state)
			HBC_ST_RUN: begin
				case (st_r.in_q)
					2'h1: begin
						req_a = HBC_DRV_LOW;
						req_b = HBC_DRV_HIGH;
					end
					2'h2: begin
						req_a = HBC_DRV_HIGH;
						req_b = HBC_DRV_LOW;
					end
					2'h3: begin
						req_a = HBC_DRV_LOW;
						req_b = HBC_DRV_LOW;
					end
					default: begin
						req_a = HBC_DRV_OFF;
						req_b = HBC_DRV_OFF;
					end
				endcase
			end
			HBC_ST_REGOFF: begin
				req_a = HBC_DRV_LOW;
				req_b = HBC_DRV_LOW;
			end
			HBC_ST_OCOFF, HBC_ST_LOCK: begin
				kill = 1'b1;
			end
			default: begin
				kill = 1'b0;
			end
		endcase
		// Faults seen this cycle kill gates without waiting a state edge
		if (oc_trip || st_r.uv || st_r.therm) begin
			kill = 1'b1;
		end
	end

	// Half-bridges with their own dead-time logic
	hbc_half_bridge u_hb_a (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.req_in     (req_a),
		.kill_in    (kill),
		.gate_out   (bridge_out_a)
	);

	hbc_half_bridge u_hb_b (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.req_in     (req_b),
		.kill_in    (kill),
		.gate_out   (bridge_out_b)
	);

	// Sense enable falls the cycle the command does, not after gate turn-off
	assign sense_en_out    = st_r.sense_on;
	assign sense_ready_out = st_r.sense_on && st_r.sdly == '0;

	assign status_out.sleep            = st_r.state == HBC_ST_SLEEP;
	assign status_out.regulating       = st_r.state == HBC_ST_REGOFF;
	assign status_out.oc_shutdown      = st_r.state == HBC_ST_OCOFF;
	assign status_out.thermal_shutdown = st_r.therm;
	assign status_out.uv_lockout       = st_r.uv;

endmodule : hbc_bridge_ctrl
`default_nettype wire

/* inc/hbc_pkg.sv */
// Package for the brushed DC H-bridge control logic.
// Assumes a 100 MHz system clock; all times are converted to cycle counts here.
package hbc_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS          = 10000;    // 100 MHz
	localparam int SHOOT_THROUGH_GAP_NS   = 200;      // Dead time per half-bridge
	localparam int REG_OFF_TIME_US        = 25;       // Current regulation off-time
	localparam int TRIP_BLANK_TIME_NS     = 1400;     // Trip comparator blanking
	localparam int TRIP_DEBOUNCE_NS       = 700;      // Trip comparator debounce
	localparam int OC_RESPONSE_NS         = 1500;     // Overcurrent response time
	localparam int OC_RETRY_MS            = 3;        // Overcurrent retry interval
	localparam int SLEEP_ENTRY_MS         = 1;        // Coast time before sleep
	localparam int SENSE_DELAY_NS         = 1100;     // Sense ready delay
	localparam int INPUT_DEBOUNCE_NS      = 100;      // Control input filter

	// Least times round up, none below one cycle
	localparam int DEAD_CYC   = (SHOOT_THROUGH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OFF_CYC    = (REG_OFF_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BLANK_CYC  = (TRIP_BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TDEB_CYC   = (TRIP_DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OCR_CYC    = (OC_RESPONSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SENSE_CYC  = (SENSE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INDEB_CYC  = (INPUT_DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Long counts: defaults for top-level parameters
	localparam int RETRY_CYC_DEF = (OC_RETRY_MS * 1000000) / (CLK_PERIOD_PS / 1000);
	localparam int SLEEP_CYC_DEF = (SLEEP_ENTRY_MS * 1000000) / (CLK_PERIOD_PS / 1000);

	localparam int CNT_W   = 20;                      // Wide enough for 3 ms
	localparam int INDEB_W = 4;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HBC_DRV_OFF  = 2'h0,                          // Both FETs off, pin high-Z
		HBC_DRV_LOW  = 2'h1,
		HBC_DRV_HIGH = 2'h2
	} hbc_drv_t;

	// Gate drive for one half-bridge
	typedef struct packed {
		logic hs;                                     // High-side gate
		logic ls;                                     // Low-side gate
	} hbc_gate_t;

	// Protection monitor inputs
	typedef struct packed {
		logic       uv_ok;                            // Supply above lockout threshold
		logic       thermal_limit;                    // Junction over shutdown temperature
		logic [3:0] oc_det;                           // Per-FET overcurrent: a_hs,a_ls,b_hs,b_ls
	} hbc_mon_t;

	// Status outputs
	typedef struct packed {
		logic sleep;
		logic regulating;
		logic oc_shutdown;
		logic thermal_shutdown;
		logic uv_lockout;
	} hbc_stat_t;

	// Main control state, Gray along the usual path
	typedef enum logic [2:0] {
		HBC_ST_SLEEP  = 3'h0,
		HBC_ST_RUN    = 3'h1,
		HBC_ST_REGOFF = 3'h3,
		HBC_ST_OCOFF  = 3'h2,
		HBC_ST_LOCK   = 3'h6
	} hbc_state_t;

endpackage : hbc_pkg

/* src/hbc_half_bridge.sv */
// One half-bridge gate driver with shoot-through gap.
// Assumes a synchronous request and a force-off that may come at any time.
`timescale 1ns/1ps
`default_nettype none
module hbc_half_bridge
	import hbc_pkg::*;
(
	input  wire  logic      sys_clk_in,      // System clock
	input  wire  logic      nrst_in,         // Async reset, active low
	input  wire  hbc_drv_t  req_in,          // Requested drive
	input  wire  logic      kill_in,         // Force both FETs off now
	output var   hbc_gate_t gate_out         // Gate drives
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		hbc_gate_t        gate;              // Gate outputs
		logic [CNT_W-1:0] gap;               // Dead-time counter
	} hbc_hb_state_t;

	hbc_hb_state_t st_r;
	hbc_hb_state_t st_nxt;

	// Next state; any change of side passes through both-off first
	always_comb begin
		st_nxt = st_r;
		if (st_r.gap != '0) begin
			st_nxt.gap = st_r.gap - 1'b1;
		end
		if (kill_in || req_in == HBC_DRV_OFF) begin
			// Turning off is always safe at once
			st_nxt.gate = '0;
			st_nxt.gap  = CNT_W'(DEAD_CYC);
		end else if (req_in == HBC_DRV_HIGH) begin
			if (st_r.gate.ls) begin
				st_nxt.gate = '0;
				st_nxt.gap  = CNT_W'(DEAD_CYC);
			end else if (st_r.gap == '0 || st_r.gate.hs) begin
				st_nxt.gate.hs = 1'b1;
			end
		end else begin
			if (st_r.gate.hs) begin
				st_nxt.gate = '0;
				st_nxt.gap  = CNT_W'(DEAD_CYC);
			end else if (st_r.gap == '0 || st_r.gate.ls) begin
				st_nxt.gate.ls = 1'b1;
			end
		end
	end

	// Register
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign gate_out = st_r.gate;

endmodule : hbc_half_bridge
`default_nettype wire

/* bench/hbc_bridge_ctrl_sva.sv */
// Checker for the H-bridge control block, bound to its ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module hbc_bridge_ctrl_sva
	import hbc_pkg::*;
#(
	parameter int RETRY_CYC = RETRY_CYC_DEF,      // Retry length in cycles
	parameter int SLEEP_CYC = SLEEP_CYC_DEF       // Sleep entry in cycles
) (
	input  wire logic      sys_clk_in,
	input  wire logic      nrst_in,
	input  wire logic      trip_current_in,
	input  wire hbc_mon_t  mon_in,
	input  wire hbc_gate_t bridge_out_a,
	input  wire hbc_gate_t bridge_out_b,
	input  wire logic      sense_en_out,
	input  wire logic      sense_ready_out,
	input  wire hbc_stat_t status_out
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	localparam int DEB_MIN = TDEB_CYC - 1;      // One cycle slack on sampling
	logic        off_a;                        // Output A floating
	logic        off_all;                      // Every gate low
	logic        oc_any;                       // Any FET overcurrent
	logic [1:0]  side_a_r;                     // Last side driven on A
	logic [7:0]  gap_a_r;                      // Cycles A has floated
	logic [7:0]  trip_run_r;                   // Consecutive trip samples
	logic [19:0] oc_len_r;                     // Length of overcurrent off
	logic [7:0]  on_run_r;                     // Cycles since gates left all-off
	assign off_a   = !bridge_out_a.hs && !bridge_out_a.ls;
	assign off_all = off_a && !bridge_out_b.hs && !bridge_out_b.ls;
	assign oc_any  = |mon_in.oc_det;
	// Track side, float time and run lengths; all but oc_len_r saturate so long idles never wrap
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			side_a_r   <= 2'h0;
			gap_a_r    <= 8'h00;
			trip_run_r <= 8'h00;
			oc_len_r   <= 20'h00000;
			on_run_r   <= 8'h00;
		end else begin
			side_a_r   <= bridge_out_a.hs ? 2'h2 : (bridge_out_a.ls ? 2'h1 : side_a_r);
			gap_a_r    <= !off_a ? 8'h00 : (gap_a_r == 8'hff ? gap_a_r : gap_a_r + 8'h01);
			trip_run_r <= !trip_current_in ? 8'h00 : (trip_run_r == 8'hff ? trip_run_r : trip_run_r + 8'h01);
			oc_len_r   <= status_out.oc_shutdown ? oc_len_r + 20'h00001 : 20'h00000;
			on_run_r   <= off_all ? 8'h00 : (on_run_r == 8'hff ? on_run_r : on_run_r + 8'h01);
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	no_shoot_a: assert property (!(bridge_out_a.hs && bridge_out_a.ls) && !(bridge_out_b.hs && bridge_out_b.ls))
		else $error("both FETs of one half-bridge on");
	dead_gap_a: assert property ((bridge_out_a.ls && side_a_r == 2'h2) || (bridge_out_a.hs && side_a_r == 2'h1)
		|-> gap_a_r >= DEAD_CYC - 1) else $error("side swap without dead gap");
	uv_off_a: assert property (!mon_in.uv_ok |=> ##1 off_all) else $error("gates on in lockout");
	therm_off_a: assert property (mon_in.thermal_limit |=> ##1 off_all) else $error("gates on when hot");
	oc_off_a: assert property (status_out.oc_shutdown && $past(status_out.oc_shutdown) |-> off_all)
		else $error("gates on in overcurrent off");
	oc_cause_a: assert property ($rose(status_out.oc_shutdown) |-> $past(oc_any))
		else $error("overcurrent off without detector");
	retry_len_a: assert property ($fell(status_out.oc_shutdown) |-> oc_len_r >= RETRY_CYC - 1 && oc_len_r <= RETRY_CYC + 2)
		else $error("retry interval wrong");
	reg_brake_a: assert property (status_out.regulating && $past(status_out.regulating)
		|-> !bridge_out_a.hs && !bridge_out_b.hs) else $error("high side on in off-time");
	reg_deb_a: assert property ($rose(status_out.regulating) |-> trip_run_r >= DEB_MIN)
		else $error("regulation before trip debounce");
	blank_win_a: assert property ($rose(status_out.regulating) |-> on_run_r >= BLANK_CYC + DEB_MIN)
		else $error("regulation inside blanking window");
	sleep_off_a: assert property (status_out.sleep |-> off_all && !sense_en_out)
		else $error("bridge active in sleep");
	ready_en_a: assert property (!sense_en_out |=> !sense_ready_out)
		else $error("sense ready without enable");
	c_reg: cover property ($rose(status_out.regulating));
	c_oc: cover property ($rose(status_out.oc_shutdown));
	c_sleep: cover property ($rose(status_out.sleep));
	c_hot: cover property ($rose(status_out.thermal_shutdown));
endmodule : hbc_bridge_ctrl_sva
bind hbc_bridge_ctrl hbc_bridge_ctrl_sva #(.RETRY_CYC(RETRY_CYC), .SLEEP_CYC(SLEEP_CYC)) i_sva (
	.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .trip_current_in(trip_current_in), .mon_in(mon_in),
	.bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b), .sense_en_out(sense_en_out),
	.sense_ready_out(sense_ready_out), .status_out(status_out));
`default_nettype wire

/* bench/hbc_host_model.sv */
// Host controller model driving the two control lines.
// Assumes requests from the bench; adds line noise only when told to.
`timescale 1ns/1ps
`default_nettype none
module hbc_host_model #(
	parameter int MIN_HOLD = 250                  // Half period at 200 kHz
) (
	input  wire logic       sys_clk_in,           // System clock
	input  wire logic [1:0] cmd_in,               // Wanted {a,b}
	input  wire logic       glitch_in,            // Noise on line a
	output logic            ctrl_a_out,           // Control line a
	output logic            ctrl_b_out            // Control line b
);
	logic [1:0] cmd_r = 2'h0;                     // Applied command
	int         hold_r = MIN_HOLD;                // Cycles since change
	// Hold each level so PWM never exceeds its ceiling
	always @(posedge sys_clk_in) begin
		if (cmd_in != cmd_r && hold_r >= MIN_HOLD) begin
			cmd_r  <= cmd_in;
			hold_r <= 0;
		end else if (hold_r < MIN_HOLD) begin
			hold_r <= hold_r + 1;
		end
	end
	assign ctrl_a_out = cmd_r[1] ^ glitch_in;
	assign ctrl_b_out = cmd_r[0];
endmodule : hbc_host_model
`default_nettype wire

/* bench/hbc_bridge_ctrl_test.sv */
// Self-checking bench for the H-bridge control block.
// Assumes the package and design sources compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
`define WAITC(c, l) for (i = 0; i < (l) && ((c) !== 1'b1); i++) @(negedge sys_clk_in);
module hbc_bridge_ctrl_test
	import hbc_pkg::*;
;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	localparam int RETRY_T = 200;                 // Short retry for run time
	localparam int SLEEP_T = 300;                 // Short sleep entry
	logic        sys_clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic [1:0]  cmd = 2'h2;                      // Host request {a,b}
	logic        glitch = 1'b0;
	logic        trip = 1'b0;
	hbc_mon_t    mon = '0;                         // Supply starts low
	logic        ctrl_a, ctrl_b, sen, srdy;
	hbc_gate_t   ga, gb;
	hbc_stat_t   st;
	logic [3:0]  gates;                           // {a.hs,a.ls,b.hs,b.ls}
	logic [31:0] lfsr = 32'h4601cfd4;
	logic [1:0]  seq[$] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h2};
	int          error_cnt = 0, n_tests = 0, cyc = 0, i, n;
	assign gates = {ga, gb};
	always #5 sys_clk_in = ~sys_clk_in;
	hbc_host_model i_host (.sys_clk_in(sys_clk_in), .cmd_in(cmd), .glitch_in(glitch),
		.ctrl_a_out(ctrl_a), .ctrl_b_out(ctrl_b));
	hbc_bridge_ctrl #(.RETRY_CYC(RETRY_T), .SLEEP_CYC(SLEEP_T)) i_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.ctrl_in_a(ctrl_a), .ctrl_in_b(ctrl_b), .trip_current_in(trip), .mon_in(mon), .bridge_out_a(ga),
		.bridge_out_b(gb), .sense_en_out(sen), .sense_ready_out(srdy), .status_out(st));
	// ----------------------------------------
	// Reference model and helpers
	// ----------------------------------------
	function automatic logic [3:0] exp_gates(input logic [1:0] c);
		logic [3:0] tbl [4] = '{4'h0, 4'h6, 4'h9, 4'h5};  // Coast, reverse, forward, brake
		return tbl[c];
	endfunction : exp_gates
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	task automatic drive(input logic [1:0] c);
		@(posedge sys_clk_in);
		cmd <= c;
	endtask : drive
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict
	// Hang guard well above the expected run
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		repeat (40) @(negedge sys_clk_in);
		`CHK(gates, 4'h0)
		`CHK(st.uv_lockout, 1'b1)
		@(posedge sys_clk_in) mon.uv_ok <= 1'b1;
		`WAITC(gates === 4'h9, 300)
		`CHK(gates, 4'h9)
		foreach (seq[k]) begin
			drive(seq[k]);
			`WAITC(gates === exp_gates(seq[k]), 400)
			`CHK(gates, exp_gates(seq[k]))
			`CHK(sen, seq[k] != 2'h0)
		end
		// Drive/brake toggling keeps sense valid throughout
		repeat (150) @(negedge sys_clk_in);
		n = 0;
		for (int k = 0; k < 4; k++) begin
			drive(k[0] ? 2'h2 : 2'h3);
			repeat (260) begin
				@(negedge sys_clk_in);
				n += (srdy !== 1'b1);
			end
		end
		`CHK(n, 0)
		// Fresh enable with trip high: blank, debounce, off-time
		drive(2'h0);
		`WAITC(gates === 4'h0, 400)
		drive(2'h2);
		trip <= 1'b1;
		`WAITC(gates === 4'h9, 400)
		`WAITC(st.regulating === 1'b1, 400)
		`CHK(i >= BLANK_CYC + TDEB_CYC - 3 && i <= BLANK_CYC + TDEB_CYC + 3, 1'b1)
		`WAITC(gates === 4'h5, 40)
		n = i;                                    // Dead gap between state and brake gates
		`CHK(gates, 4'h5)
		repeat (OFF_CYC + 100) @(negedge sys_clk_in);
		`CHK(st.regulating, 1'b1)
		@(posedge sys_clk_in) trip <= 1'b0;
		`WAITC(st.regulating !== 1'b1, OFF_CYC)
		n = n + i + OFF_CYC + 100;
		`CHK(n >= 2 * OFF_CYC - 4 && n <= 2 * OFF_CYC + 4, 1'b1)
		`WAITC(gates === 4'h9, 60)
		`CHK(gates, 4'h9)
		// Input change aborts the off-time
		@(posedge sys_clk_in) trip <= 1'b1;
		`WAITC(st.regulating === 1'b1, BLANK_CYC + TDEB_CYC + 20)
		`CHK(st.regulating, 1'b1)
		repeat (500) @(negedge sys_clk_in);
		drive(2'h1);
		trip <= 1'b0;
		`WAITC(st.regulating !== 1'b1, 300)
		`CHK(i < 30, 1'b1)
		`WAITC(gates === 4'h6, 60)
		`CHK(gates, 4'h6)
		// Overcurrent on a random FET, persisting through one retry
		lfsr = lfsr_next(lfsr);
		@(posedge sys_clk_in) mon.oc_det <= 4'h1 << lfsr[1:0];
		`WAITC(st.oc_shutdown === 1'b1, OCR_CYC + 20)
		`CHK(i >= OCR_CYC - 2 && i <= OCR_CYC + 3, 1'b1)
		@(negedge sys_clk_in);
		`CHK(gates, 4'h0)
		`WAITC(st.oc_shutdown !== 1'b1, RETRY_T + 20)
		`CHK(i >= RETRY_T - 4 && i <= RETRY_T + 3, 1'b1)
		`WAITC(st.oc_shutdown === 1'b1, OCR_CYC + 40)
		`CHK(st.oc_shutdown, 1'b1)
		@(posedge sys_clk_in) mon.oc_det <= 4'h0;
		`WAITC(gates === 4'h6, RETRY_T + 100)
		`CHK(gates, 4'h6)
		// Thermal then supply faults override the decode
		@(posedge sys_clk_in) mon.thermal_limit <= 1'b1;
		repeat (3) @(negedge sys_clk_in);
		`CHK({gates, st.thermal_shutdown}, 5'h01)
		@(posedge sys_clk_in) mon.thermal_limit <= 1'b0;
		`WAITC(gates === 4'h6, 60)
		`CHK(gates, 4'h6)
		@(posedge sys_clk_in) mon.uv_ok <= 1'b0;
		repeat (3) @(negedge sys_clk_in);
		`CHK({gates, st.uv_lockout}, 5'h01)
		@(posedge sys_clk_in) mon.uv_ok <= 1'b1;
		`WAITC(gates === 4'h6, 100)
		`CHK(gates, 4'h6)
		// Coast into sleep, then a short noise pulse must not wake it
		drive(2'h0);
		`WAITC(st.sleep === 1'b1, SLEEP_T + 300)
		`CHK(i >= SLEEP_T && i <= SLEEP_T + 20, 1'b1)
		lfsr = lfsr_next(lfsr);
		@(posedge sys_clk_in) glitch <= 1'b1;
		repeat (1 + lfsr[1:0]) @(posedge sys_clk_in);
		glitch <= 1'b0;
		repeat (30) @(negedge sys_clk_in);
		`CHK({gates, st.sleep}, 5'h01)
		give_verdict();
	end
endmodule : hbc_bridge_ctrl_test
`default_nettype wire
